// ---- design/prng_health_gate.sv ----
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RQ1) a stuck-source check runs from start and on failure no word is ever released.
// (RQ2) on total failure mid-run every word holding later raw bits is dropped.
// (RQ3) a windowed ones-count test runs from start-up and all through operation.
// (RQ4) no word leaves before the start-up windows pass, nor while a defect stands.
// (RQ5) the test scans every raw bit with no gap between windows.
// (RQ6) words go to the consumer 32 bits wide.
// (RQ7) each window's ones balance must keep per-bit entropy above 0.997; the 96..160 band accepts down to about 0.954.
// (RQ8) valid marks only cleared words, consumer takes on valid and ready, failures show as flags.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module prng_health_gate
  import prng_pkg::*;
#(
  parameter int WIN       = prng_pkg::WIN_LEN,
  parameter int STUCK_MAX = prng_pkg::STUCK_LIMIT
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        rawBit,
  input  wire logic                        rawValid,
  output logic                             rndValid,
  input  wire logic                        rndReady,
  output logic      [prng_pkg::WORD_W-1:0] rndData,
  output logic                             totalFail,
  output logic                             defect,
  output logic                             startupDone
);
  import prng_pkg::*;

  prng_state_t      state;
  logic [15:0]      runLen;
  logic             lastBit;
  logic [15:0]      winCnt;
  logic [15:0]      onesCnt;
  logic [3:0]       passWins;
  logic [WORD_W-1:0] shiftReg;
  logic [5:0]       bitCnt;
  logic [WORD_W-1:0] pendWord;
  logic             pendValid;
  logic             fifoInReady;
  logic             fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  logic             stuckNow;
  logic             winEnd;
  logic             winBad;
  logic             releaseOk;
  logic             flush;

  // ones-count bounds are the fixed ONES_LO and ONES_HI, not taken from the entropy figure
  function automatic logic window_bad(input logic [15:0] ones);
    return (ones < 16'(ONES_LO)) || (ones > 16'(ONES_HI));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // total failure detector
  assign stuckNow = rawValid && (rawBit == lastBit) && (runLen >= 16'(STUCK_MAX - 1)); // RQ1 RQ2

  always_ff @(posedge clk) begin
    if (!resetn) begin
      runLen  <= 16'h0000;
      lastBit <= 1'b0;
    end else if (rawValid) begin
      lastBit <= rawBit;
      // a fresh run counts its own first bit, so reset leaves no phantom bit
      if (rawBit != lastBit || runLen == 16'h0000) begin
        runLen <= 16'h0001;
      end else if (runLen != 16'hFFFF) begin
        runLen <= runLen + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // online test, back-to-back windows
  assign winEnd = rawValid && (winCnt == 16'(WIN - 1)); // RQ5
  assign winBad = window_bad(onesCnt + 16'(rawBit)); // RQ7

  always_ff @(posedge clk) begin
    if (!resetn) begin
      winCnt  <= 16'h0000;
      onesCnt <= 16'h0000;
    end else if (rawValid) begin
      if (winEnd) begin
        winCnt  <= 16'h0000; // RQ5
        onesCnt <= 16'h0000;
      end else begin
        winCnt  <= winCnt + 16'h0001;
        onesCnt <= onesCnt + 16'(rawBit); // RQ3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      passWins <= 4'h0;
    end else if (winEnd && state == PRNG_START) begin
      passWins <= winBad ? 4'h0 : passWins + 4'h1; // RQ4
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gate state: failure is latched until reset, safest reaction
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= PRNG_START;
    end else begin
      unique case (state)
        PRNG_START: begin
          if (stuckNow) begin
            state <= PRNG_FAIL; // RQ1
          end else if (winEnd && !winBad && passWins == 4'(STARTUP_WINS - 1)) begin
            state <= PRNG_RUN; // RQ4
          end
        end
        PRNG_RUN: begin
          if (stuckNow) begin
            state <= PRNG_FAIL; // RQ2
          end
        end
        PRNG_FAIL: state <= PRNG_FAIL;
        default:   state <= PRNG_FAIL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      defect <= 1'b0;
    end else if (winEnd) begin
      defect <= winBad; // RQ3 RQ4
    end
  end

  assign totalFail   = (state == PRNG_FAIL); // RQ8
  assign startupDone = (state != PRNG_START);
  assign releaseOk   = (state == PRNG_RUN) && !defect && !stuckNow;
  // a failing or defective window discards anything still unread
  assign flush       = stuckNow || (winEnd && winBad) || (state == PRNG_FAIL); // RQ2

  //////////////////////////////////////////////////////////////////////////
  // word assembly, bits reach the fifo before their window is judged
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shiftReg <= '0;
      bitCnt   <= 6'h00;
    end else if (flush) begin
      bitCnt <= 6'h00;
    end else if (rawValid) begin
      shiftReg <= {shiftReg[WORD_W-2:0], rawBit};
      bitCnt   <= (bitCnt == 6'(WORD_W - 1)) ? 6'h00 : bitCnt + 6'h01; // RQ6
    end
  end

  // limitation: while the fifo is full each newly finished word overwrites the pending one, the source never stalls
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pendValid <= 1'b0;
      pendWord  <= '0;
    end else if (flush) begin
      pendValid <= 1'b0;
    end else if (rawValid && bitCnt == 6'(WORD_W - 1)) begin
      pendValid <= (state != PRNG_FAIL);
      pendWord  <= {shiftReg[WORD_W-2:0], rawBit}; // RQ6
    end else if (fifoInReady) begin
      pendValid <= 1'b0;
    end
  end

  prng_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) prng_fifo_i (
    .clk     (clk),
    .resetn  (resetn),
    .flush   (flush),
    .inValid (pendValid),
    .inReady (fifoInReady),
    .inData  (pendWord),
    .outValid(fifoOutValid),
    .outReady(rndReady && releaseOk),
    .outData (fifoOutData)
  );

  assign rndValid = fifoOutValid && releaseOk; // RQ4 RQ8
  assign rndData  = releaseOk ? fifoOutData : '0; // RQ1

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_fail_blocks;
    @(posedge clk) disable iff (!resetn) totalFail |-> !rndValid;
  endproperty
  a_fail_blocks: assert property (p_fail_blocks) else $error("word out after failure"); // RQ1

  property p_fail_sticky;
    @(posedge clk) disable iff (!resetn) totalFail |=> totalFail [*4];
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped"); // RQ2

  property p_stuck_fails;
    @(posedge clk) disable iff (!resetn) stuckNow |=> totalFail;
  endproperty
  a_stuck_fails: assert property (p_stuck_fails) else $error("stuck source not caught"); // RQ2

  property p_no_early;
    @(posedge clk) disable iff (!resetn) !startupDone |-> !rndValid;
  endproperty
  a_no_early: assert property (p_no_early) else $error("word before start-up pass"); // RQ4

  property p_defect_blocks;
    @(posedge clk) disable iff (!resetn) defect |-> !rndValid;
  endproperty
  a_defect_blocks: assert property (p_defect_blocks) else $error("word during defect"); // RQ4

  property p_bad_window;
    @(posedge clk) disable iff (!resetn) (winEnd && winBad) |=> defect;
  endproperty
  a_bad_window: assert property (p_bad_window) else $error("bad window not flagged"); // RQ3

  sequence s_win_wrap;
    winEnd ##1 (winCnt == 16'h0000);
  endsequence
  property p_no_gap;
    @(posedge clk) disable iff (!resetn) winEnd |-> s_win_wrap;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("window gap"); // RQ5

  property p_data_stable;
    @(posedge clk) disable iff (!resetn) (rndValid && !rndReady) |=> (rndValid -> $stable(rndData));
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("word changed while waiting"); // RQ8

  // word, window and failure-output bookkeeping
  sequence s_word_done;
    rawValid && (bitCnt == 6'(WORD_W - 1)) && !flush && (state != PRNG_FAIL);
  endsequence

  sequence s_last_good;
    (state == PRNG_START) && (passWins == 4'(STARTUP_WINS - 1)) && winEnd && !winBad && !stuckNow;
  endsequence

  sequence s_dark;
    (totalFail && !rndValid && (rndData == '0)) [*4];
  endsequence

  property p_flush_empties;
    @(posedge clk) disable iff (!resetn) flush |=> !fifoOutValid;
  endproperty
  a_flush_empties: assert property (p_flush_empties) else $error("buffer kept words after flush"); // RQ2

  property p_fail_empty;
    @(posedge clk) disable iff (!resetn) totalFail |-> (!fifoOutValid && !pendValid);
  endproperty
  a_fail_empty: assert property (p_fail_empty) else $error("words held after failure"); // RQ1

  property p_stuck_dark;
    @(posedge clk) disable iff (!resetn) stuckNow |=> s_dark;
  endproperty
  a_stuck_dark: assert property (p_stuck_dark) else $error("output not dark after stuck run"); // RQ2

  property p_good_clears;
    @(posedge clk) disable iff (!resetn) (winEnd && !winBad) |=> !defect;
  endproperty
  a_good_clears: assert property (p_good_clears) else $error("defect kept after good window"); // RQ3

  property p_bad_restarts;
    @(posedge clk) disable iff (!resetn) (winEnd && winBad && (state == PRNG_START)) |=> (passWins == 4'h0);
  endproperty
  a_bad_restarts: assert property (p_bad_restarts) else $error("start-up count kept after bad window"); // RQ4

  property p_opens;
    @(posedge clk) disable iff (!resetn) s_last_good |=> (state == PRNG_RUN);
  endproperty
  a_opens: assert property (p_opens) else $error("gate not opened after start-up windows"); // RQ4

  property p_open_after_passes;
    @(posedge clk) disable iff (!resetn) $rose(state == PRNG_RUN) |-> ($past(passWins) == 4'(STARTUP_WINS - 1));
  endproperty
  a_open_after_passes: assert property (p_open_after_passes) else $error("gate opened too soon"); // RQ4

  property p_word_pending;
    @(posedge clk) disable iff (!resetn) s_word_done |=> pendValid;
  endproperty
  a_word_pending: assert property (p_word_pending) else $error("finished word not offered"); // RQ6

  property p_bit_range;
    @(posedge clk) disable iff (!resetn) bitCnt < 6'(WORD_W);
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("word bit count out of range"); // RQ6

  property p_win_range;
    @(posedge clk) disable iff (!resetn) winCnt < 16'(WIN);
  endproperty
  a_win_range: assert property (p_win_range) else $error("window count out of range"); // RQ5

  property p_ones_range;
    @(posedge clk) disable iff (!resetn) onesCnt <= winCnt;
  endproperty
  a_ones_range: assert property (p_ones_range) else $error("ones count above bit count"); // RQ3

  property p_run_restart;
    @(posedge clk) disable iff (!resetn) (rawValid && (rawBit != lastBit)) |=> (runLen == 16'h0001);
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("run length not restarted"); // RQ1

  property p_gate_opens;
    @(posedge clk) disable iff (!resetn) ((state == PRNG_RUN) && !defect && !stuckNow && fifoOutValid) |-> rndValid;
  endproperty
  a_gate_opens: assert property (p_gate_opens) else $error("cleared word withheld"); // RQ8
endmodule // prng_health_gate
`default_nettype wire

// ---- include/prng_pkg.sv ----
package prng_pkg;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  // total failure: raw stream stuck at one level this long
  localparam int STUCK_LIMIT = 32;
  // online test window and tolerated ones count in it
  localparam int WIN_LEN = 256;
  localparam int ONES_LO = 96;
  localparam int ONES_HI = 160;
  // startup windows that must pass before release
  localparam int STARTUP_WINS = 2;
  // entropy bound 0.997 expressed as per-mille figure of the ones balance
  localparam int ENTROPY_PERMILLE = 997;
  typedef enum logic [1:0] {
    PRNG_START = 2'b00,
    PRNG_RUN   = 2'b01,
    PRNG_FAIL  = 2'b10
  } prng_state_t;
endpackage

// ---- design/prng_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module prng_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (pop) begin
        rdPtr <= rdPtr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // prng_fifo
`default_nettype wire

// ---- tb/prng_consumer.sv ----
`timescale 1ns/1ps
`default_nettype none
module prng_consumer
  import prng_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [1:0]                  mode,
  input  wire logic                        rndValid,
  input  wire logic [prng_pkg::WORD_W-1:0] rndData,
  output logic                             rndReady,
  output logic      [15:0]                 nTaken
);
  import prng_pkg::*;
  // mode 0 stalls, 1 always ready, 2 ready every other cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rndReady <= 1'b0;
    end else begin
      rndReady <= (mode == 2'h1) | ((mode == 2'h2) & ~rndReady);
    end
  end
  // the bench compares differences or counts taken from reset, so clearing on reset is harmless
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nTaken <= 16'h0000;
    end else if (rndValid && rndReady) begin
      nTaken <= nTaken + 16'h0001;
    end
  end
endmodule // prng_consumer
`default_nettype wire

// ---- tb/tb_physical_rng_health_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_physical_rng_health_gate;
  import prng_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        rawBit = 1'b0;
  logic        rawValid = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        rndValid, rndReady, totalFail, defect, startupDone;
  logic [31:0] rndData;
  logic [15:0] nTaken, base;
  logic [31:0] expWord = 32'hAAAAAAAA;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  prng_health_gate prng_health_gate_i (.clk(clk), .resetn(resetn), .rawBit(rawBit), .rawValid(rawValid),
    .rndValid(rndValid), .rndReady(rndReady), .rndData(rndData), .totalFail(totalFail), .defect(defect),
    .startupDone(startupDone));
  prng_consumer prng_consumer_i (.clk(clk), .resetn(resetn), .mode(mode), .rndValid(rndValid),
    .rndData(rndData), .rndReady(rndReady), .nTaken(nTaken));
  initial begin
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // msb first; the idle gap lets flags settle and a released window drain
  task automatic send_words(input logic [31:0] w, input int n);
    for (int k = 0; k < n; k++) begin
      for (int i = 31; i >= 0; i--) begin
        @(posedge clk);
        rawValid <= 1'b1;
        rawBit   <= w[i];
      end
    end
    @(posedge clk);
    rawValid <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // every released word must be the pattern being sent and the gate fully open
  always @(negedge clk) begin
    if (resetn && rndValid === 1'b1) begin
      check(rndData, expWord);
      check({29'h0, totalFail, defect, startupDone}, 32'h00000001);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_startup_fill();
    send_words(32'hAAAAAAAA, 8);
    check({31'h0, startupDone}, 32'h00000000);
    send_words(32'hAAAAAAAA, 8);
    check({31'h0, startupDone}, 32'h00000001);
    // consumer stalls; one word waits in the pending stage beyond the full buffer
    send_words(32'hAAAAAAAA, 16);
    mode <= 2'h2;
    repeat (60) @(posedge clk);
    check({16'h0, nTaken}, 32'h00000011);
  endtask
  task automatic t_defect();
    mode <= 2'h1;
    // 31-long runs stay below the stuck limit, ones far above the band
    // words of a window still open flow out before the window is judged
    expWord = 32'hFFFFFFFE;
    send_words(32'hFFFFFFFE, 8);
    check({31'h0, defect}, 32'h00000001);
    check({31'h0, rndValid}, 32'h00000000);
    expWord = 32'hAAAAAAAA;
    send_words(32'hAAAAAAAA, 8);
    check({31'h0, defect}, 32'h00000000);
    // ones far below the band
    expWord = 32'h80000000;
    send_words(32'h80000000, 8);
    check({31'h0, defect}, 32'h00000001);
    check({31'h0, rndValid}, 32'h00000000);
    expWord = 32'hAAAAAAAA;
    send_words(32'hAAAAAAAA, 8);
    check({31'h0, defect}, 32'h00000000);
    base = nTaken;
    send_words(32'hAAAAAAAA, 1);
    check({16'h0, nTaken - base}, 32'h00000001);
  endtask
  task automatic t_stuck_run();
    send_words(32'hAAAAAAAA, 1);
    send_words(32'h00000000, 2);
    check({31'h0, totalFail}, 32'h00000001);
    base = nTaken;
    send_words(32'hAAAAAAAA, 16);
    check({16'h0, nTaken - base}, 32'h00000000);
  endtask
  task automatic t_stuck_start();
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({29'h0, totalFail, defect, startupDone}, 32'h00000000);
    base = nTaken;
    send_words(32'h00000000, 8);
    check({31'h0, totalFail}, 32'h00000001);
    send_words(32'hAAAAAAAA, 16);
    check({16'h0, nTaken - base}, 32'h00000000);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_startup_fill();
    t_defect();
    t_stuck_run();
    t_stuck_start();
    test_done();
  end
endmodule // tb_physical_rng_health_gate
`default_nettype wire
